//--- verilog/skip_stop_pkg.sv
// Constants and types shared by the skip, stop and subtract executor.
package skip_stop_pkg;
   // Register byte offsets on the APB port.
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_PC = 8'h08;
   localparam logic [7:0] OFS_MEM_ADDR = 8'h0C;
   localparam logic [7:0] OFS_MEM_DATA = 8'h10;
   // Status register field positions.
   localparam int ST_ACC_LSB = 0;
   localparam int ST_CARRY = 4;
   localparam int ST_ZERO = 5;
   localparam int ST_SLEEP = 6;
   // Opcode prefixes and the full stop word.
   localparam logic [8:0] SKIP3_PREFIX = 9'h115;
   localparam logic [8:0] SUB_MEM_PREFIX = 9'h034;
   localparam logic [8:0] SUBTRACT_WRITE_BACK_MEM_PREFIX = 9'h036;
   localparam logic [7:0] SUB_IMM_PREFIX = 8'h1E;
   localparam logic [7:0] SUBTRACT_WRITE_BACK_IMM_PREFIX = 8'h1F;
   localparam logic [15:0] STOP_CODE = 16'h0060;
   // Working registers sit in the lowest sixteen data memory nibbles.
   localparam logic [2:0] WR_BANK = 3'h0;
   localparam int MEM_DEPTH = 128;
   // Values after reset and program counter steps.
   localparam logic [3:0] ACC_RST = 4'h0;
   localparam logic [10:0] PC_RST = 11'h000;
   localparam logic [6:0] MEM_ADDR_RST = 7'h00;
   localparam logic [15:0] OPCODE_RST = 16'h0000;
   localparam logic WAKE_IDLE = 1'b1;
   localparam logic [10:0] PC_STEP = 11'h001;
   localparam logic [10:0] PC_SKIP = 11'h002;
   typedef enum logic [2:0] {
      OP_OTHER, OP_SKIP3, OP_STOP, OP_SUB_MEM, OP_SUBTRACT_WRITE_BACK_MEM, OP_SUB_IMM,
      OP_SUBTRACT_WRITE_BACK_IMM
   } op_t;
endpackage

//--- verilog/exec_if.sv
// Link between the executor core and its decode and subtract unit.
`timescale 1ns/1ps
interface exec_if;
   logic [15:0] opcode;
   logic [3:0] acc;
   logic [3:0] mem_rd;
   skip_stop_pkg::op_t op;
   logic [6:0] addr;
   logic [3:0] operand_a;
   logic [3:0] operand_b;
   logic [3:0] result;
   logic carry;
   logic zero;
   modport core (output opcode, acc, mem_rd,
      input op, addr, operand_a, operand_b, result, carry, zero);
   modport exec (input opcode, acc, mem_rd,
      output op, addr, operand_a, operand_b, result, carry, zero);
endinterface

//--- verilog/subtract_decode.sv
// Opcode decode and 4-bit subtractor for the executor.
`timescale 1ns/1ps
module subtract_decode (
   exec_if.exec bus // Opcode in, decoded kind and arithmetic out.
);
   logic [4:0] diff;

   // Decode the opcode; immediate forms address a working register.
   always_comb begin
      bus.op = skip_stop_pkg::OP_OTHER;
      bus.addr = bus.opcode[6:0];
      bus.operand_b = bus.acc;
      if (bus.opcode[15:7] == skip_stop_pkg::SKIP3_PREFIX) begin
         bus.op = skip_stop_pkg::OP_SKIP3;
      end else if (bus.opcode[15:7] == skip_stop_pkg::SUB_MEM_PREFIX) begin
         bus.op = skip_stop_pkg::OP_SUB_MEM;
      end else if (bus.opcode[15:7] == skip_stop_pkg::SUBTRACT_WRITE_BACK_MEM_PREFIX) begin
         bus.op = skip_stop_pkg::OP_SUBTRACT_WRITE_BACK_MEM;
      end else if (bus.opcode[15:8] == skip_stop_pkg::SUB_IMM_PREFIX) begin
         bus.op = skip_stop_pkg::OP_SUB_IMM;
         bus.addr = {skip_stop_pkg::WR_BANK, bus.opcode[3:0]};
         bus.operand_b = bus.opcode[7:4];
      end else if (bus.opcode[15:8] == skip_stop_pkg::SUBTRACT_WRITE_BACK_IMM_PREFIX) begin
         bus.op = skip_stop_pkg::OP_SUBTRACT_WRITE_BACK_IMM;
         bus.addr = {skip_stop_pkg::WR_BANK, bus.opcode[3:0]};
         bus.operand_b = bus.opcode[7:4];
      end else if (bus.opcode == skip_stop_pkg::STOP_CODE) begin
         bus.op = skip_stop_pkg::OP_STOP;
      end
   end

   // Adding the inverse plus one leaves carry high exactly when no borrow.
   assign bus.operand_a = bus.mem_rd;
   assign diff = {1'b0, bus.operand_a} + {1'b0, ~bus.operand_b} + 5'h01;
   assign bus.result = diff[3:0];
   assign bus.carry = diff[4];
   assign bus.zero = (diff[3:0] == 4'h0);
endmodule

//--- verilog/skip_stop_subtract_exec.sv
// Executor for bit-3 skip, stop mode and subtract instructions over APB.
`timescale 1ns/1ps
module skip_stop_subtract_exec (
   input wire logic pclk, // Core clock, 100 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready, always high.
   output logic pslverr, // APB error for unmapped or refused access.
   input wire logic wake_input_port, // External wake pin.
   output logic osc_halt // High while the oscillator is stopped.
);
   logic [3:0] data_mem [skip_stop_pkg::MEM_DEPTH];
   logic [3:0] accumulator;
   logic carry_flag;
   logic zero_flag;
   logic [10:0] program_counter;
   logic [6:0] mem_addr;
   logic [15:0] last_opcode;
   logic sleeping;
   logic wake_meta;
   logic wake_sync;
   logic wake_prev;
   logic wake_fall;
   logic wr_access;
   logic exec_go;
   logic is_sub;
   logic writes_mem;
   logic mapped;
   logic [31:0] next_prdata;

   exec_if link ();

   subtract_decode u_decode (
      .bus(link)
   );

   // The opcode is taken straight from the bus so it executes on that edge.
   assign link.opcode = pwdata[15:0];
   assign link.acc = accumulator;
   assign link.mem_rd = data_mem[link.addr];

   // Decoded kinds that select the destinations.
   assign is_sub = (link.op == skip_stop_pkg::OP_SUB_MEM) ||
      (link.op == skip_stop_pkg::OP_SUBTRACT_WRITE_BACK_MEM) ||
      (link.op == skip_stop_pkg::OP_SUB_IMM) ||
      (link.op == skip_stop_pkg::OP_SUBTRACT_WRITE_BACK_IMM);
   assign writes_mem = (link.op == skip_stop_pkg::OP_SUBTRACT_WRITE_BACK_MEM) ||
      (link.op == skip_stop_pkg::OP_SUBTRACT_WRITE_BACK_IMM);

   // APB decode; a write to the opcode register is one machine cycle.
   assign wr_access = psel && penable && pwrite;
   assign mapped = (paddr == skip_stop_pkg::OFS_INSTR) ||
      (paddr == skip_stop_pkg::OFS_STATUS) ||
      (paddr == skip_stop_pkg::OFS_PC) ||
      (paddr == skip_stop_pkg::OFS_MEM_ADDR) ||
      (paddr == skip_stop_pkg::OFS_MEM_DATA);
   assign exec_go = wr_access && (paddr == skip_stop_pkg::OFS_INSTR) &&
      !sleeping;
   assign pready = 1'b1;
   // A sleeping core cannot take an opcode, so the write is flagged.
   assign pslverr = psel && penable && (!mapped || (pwrite && sleeping &&
      (paddr == skip_stop_pkg::OFS_INSTR)));
   assign osc_halt = sleeping;

   // Wake pin passes two flip-flops before the edge detector sees it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_meta <= skip_stop_pkg::WAKE_IDLE;
         wake_sync <= skip_stop_pkg::WAKE_IDLE;
         wake_prev <= skip_stop_pkg::WAKE_IDLE;
      end else begin
         wake_meta <= wake_input_port;
         wake_sync <= wake_meta;
         wake_prev <= wake_sync;
      end
   end
   assign wake_fall = wake_prev && !wake_sync;

   // Sleep state; edges that arrive while awake are simply ignored.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleeping <= 1'b0;
      end else if (exec_go && (link.op == skip_stop_pkg::OP_STOP)) begin
         sleeping <= 1'b1;
      end else if (sleeping && wake_fall) begin
         sleeping <= 1'b0;
      end
   end

   // Program counter; stop already stepped it, so wake resumes past it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         program_counter <= skip_stop_pkg::PC_RST;
      end else if (exec_go) begin
         if ((link.op == skip_stop_pkg::OP_SKIP3) && link.mem_rd[3]) begin
            program_counter <= program_counter + skip_stop_pkg::PC_SKIP;
         end else begin
            program_counter <= program_counter + skip_stop_pkg::PC_STEP;
         end
      end else if (wr_access && (paddr == skip_stop_pkg::OFS_PC)) begin
         program_counter <= pwdata[10:0];
      end
   end

   // Accumulator and flags; software may preset them through status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accumulator <= skip_stop_pkg::ACC_RST;
         carry_flag <= 1'b0;
         zero_flag <= 1'b0;
      end else if (exec_go && is_sub) begin
         accumulator <= link.result;
         carry_flag <= link.carry;
         zero_flag <= link.zero;
      end else if (wr_access && (paddr == skip_stop_pkg::OFS_STATUS)) begin
         accumulator <= pwdata[skip_stop_pkg::ST_ACC_LSB +: 4];
         carry_flag <= pwdata[skip_stop_pkg::ST_CARRY];
         zero_flag <= pwdata[skip_stop_pkg::ST_ZERO];
      end
   end

   // Data memory holds no reset; it is contents, not control state.
   always_ff @(posedge pclk) begin
      if (exec_go && writes_mem) begin
         data_mem[link.addr] <= link.result;
      end else if (wr_access && (paddr == skip_stop_pkg::OFS_MEM_DATA)) begin
         data_mem[mem_addr] <= pwdata[3:0];
      end
   end

   // Memory window pointer and the last opcode taken.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_addr <= skip_stop_pkg::MEM_ADDR_RST;
         last_opcode <= skip_stop_pkg::OPCODE_RST;
      end else begin
         if (wr_access && (paddr == skip_stop_pkg::OFS_MEM_ADDR)) begin
            mem_addr <= pwdata[6:0];
         end
         if (exec_go) begin
            last_opcode <= pwdata[15:0];
         end
      end
   end

   // Read data is chosen in the setup cycle and held through the access.
   always_comb begin
      next_prdata = 32'h00000000;
      unique case (paddr)
         skip_stop_pkg::OFS_INSTR: next_prdata[15:0] = last_opcode;
         skip_stop_pkg::OFS_STATUS: begin
            next_prdata[skip_stop_pkg::ST_ACC_LSB +: 4] = accumulator;
            next_prdata[skip_stop_pkg::ST_CARRY] = carry_flag;
            next_prdata[skip_stop_pkg::ST_ZERO] = zero_flag;
            next_prdata[skip_stop_pkg::ST_SLEEP] = sleeping;
         end
         skip_stop_pkg::OFS_PC: next_prdata[10:0] = program_counter;
         skip_stop_pkg::OFS_MEM_ADDR: next_prdata[6:0] = mem_addr;
         skip_stop_pkg::OFS_MEM_DATA: next_prdata[3:0] = data_mem[mem_addr];
         default: next_prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // Checks on the executed instructions.
   a_skip_taken: assert property (
      @(posedge pclk) disable iff (!presetn)
      exec_go && (link.op == skip_stop_pkg::OP_SKIP3) && link.mem_rd[3]
      |=> program_counter == $past(program_counter) + skip_stop_pkg::PC_SKIP)
      else $error("Bit-3 skip did not advance by two.");

   a_skip_not_taken: assert property (
      @(posedge pclk) disable iff (!presetn)
      exec_go && (link.op == skip_stop_pkg::OP_SKIP3) && !link.mem_rd[3]
      |=> program_counter == $past(program_counter) + skip_stop_pkg::PC_STEP &&
      $stable(accumulator))
      else $error("Bit-3 skip without the bit did not step by one.");

   a_stop_enters: assert property (
      @(posedge pclk) disable iff (!presetn)
      exec_go && (link.op == skip_stop_pkg::OP_STOP)
      |=> osc_halt && sleeping &&
      program_counter == $past(program_counter) + skip_stop_pkg::PC_STEP)
      else $error("Stop did not halt the oscillator in one cycle.");

   a_wake_resume: assert property (
      @(posedge pclk) disable iff (!presetn)
      sleeping && wake_prev && !wake_sync
      |=> !osc_halt && $stable(program_counter))
      else $error("Falling wake edge did not end sleep.");

   a_sleep_holds: assert property (
      @(posedge pclk) disable iff (!presetn)
      sleeping && !(wake_prev && !wake_sync) |=> sleeping && !$past(exec_go))
      else $error("Sleep ended without a wake edge.");

   a_sub_acc_only: assert property (
      @(posedge pclk) disable iff (!presetn)
      exec_go && (link.op == skip_stop_pkg::OP_SUB_MEM)
      |=> accumulator == 4'($past(link.mem_rd) - $past(accumulator)) &&
      data_mem[$past(link.addr)] == $past(link.mem_rd))
      else $error("Memory subtract wrong or memory disturbed.");

   a_sub_imm_only: assert property (
      @(posedge pclk) disable iff (!presetn)
      exec_go && (link.op == skip_stop_pkg::OP_SUB_IMM)
      |=> accumulator == 4'($past(link.mem_rd) - $past(pwdata[7:4])) &&
      data_mem[$past(link.addr)] == $past(link.mem_rd))
      else $error("Immediate subtract wrong or register disturbed.");

   a_subtract_write_back_mem_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      exec_go && (link.op == skip_stop_pkg::OP_SUBTRACT_WRITE_BACK_MEM)
      |=> data_mem[$past(link.addr)] == accumulator &&
      accumulator == 4'($past(link.mem_rd) - $past(accumulator)))
      else $error("Write-back memory subtract missed a destination.");

   a_subtract_write_back_imm_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      exec_go && (link.op == skip_stop_pkg::OP_SUBTRACT_WRITE_BACK_IMM)
      |=> data_mem[$past(link.addr)] == accumulator &&
      accumulator == 4'($past(link.mem_rd) - $past(pwdata[7:4])))
      else $error("Write-back immediate subtract missed a destination.");

   a_flags_borrow: assert property (
      @(posedge pclk) disable iff (!presetn)
      exec_go && is_sub
      |=> carry_flag == ($past(link.operand_a) >= $past(link.operand_b)) &&
      zero_flag == (accumulator == 4'h0))
      else $error("Carry or zero flag wrong after subtract.");
endmodule

//--- dv/prog_mem_model.sv
// Program memory model that feeds a short test program to the executor.
`timescale 1ns/1ps
module prog_mem_model (
   input wire logic [10:0] fetch_addr, // Word address from the counter.
   output logic [15:0] fetch_word // Instruction word at that address.
);
   // Unused words read as all ones, which decodes as none of the tested
   // instructions, so a stray fetch cannot pass for a good one.
   always_comb begin
      case (fetch_addr)
         11'h000: fetch_word = 16'h8A85;
         11'h001: fetch_word = 16'h1A05;
         11'h002: fetch_word = skip_stop_pkg::STOP_CODE;
         11'h003: fetch_word = 16'h1F35;
         default: fetch_word = 16'hFFFF;
      endcase
   end
endmodule

//--- dv/tb_skip_stop_subtract_exec.sv
// Self-checking testbench for the skip, stop and subtract executor.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_skip_stop_subtract_exec;
   localparam logic [7:0] A_IN = skip_stop_pkg::OFS_INSTR;
   localparam logic [7:0] A_ST = skip_stop_pkg::OFS_STATUS;
   localparam logic [7:0] A_PC = skip_stop_pkg::OFS_PC;
   localparam logic [7:0] A_MA = skip_stop_pkg::OFS_MEM_ADDR;
   localparam logic [7:0] A_MD = skip_stop_pkg::OFS_MEM_DATA;
   typedef struct {
      logic [3:0] mem, acc;
      logic [15:0] op;
      logic [3:0] racc;
      logic c, z;
      logic [3:0] rmem;
      logic [10:0] pc;
   } row_t;
   // Nibble at address 5, preset accumulator, opcode, then expected results.
   row_t rows[9] = '{
      '{4'h9, 4'h3, 16'h1A05, 4'h6, 1'h1, 1'h0, 4'h9, 11'h011},
      '{4'h2, 4'h5, 16'h1A05, 4'hD, 1'h0, 1'h0, 4'h2, 11'h011},
      '{4'h7, 4'h7, 16'h1B05, 4'h0, 1'h1, 1'h1, 4'h0, 11'h011},
      '{4'h3, 4'hA, 16'h1E45, 4'hF, 1'h0, 1'h0, 4'h3, 11'h011},
      '{4'h8, 4'h0, 16'h1F25, 4'h6, 1'h1, 1'h0, 4'h6, 11'h011},
      '{4'h4, 4'h4, 16'h1F45, 4'h0, 1'h1, 1'h1, 4'h0, 11'h011},
      '{4'h8, 4'h1, 16'h8A85, 4'h1, 1'h1, 1'h1, 4'h8, 11'h012},
      '{4'h7, 4'h1, 16'h8A85, 4'h1, 1'h1, 1'h1, 4'h7, 11'h011},
      '{4'h4, 4'h1, 16'h8A05, 4'h1, 1'h1, 1'h1, 4'h4, 11'h011}};
   logic pclk, presetn, psel, penable, pwrite, wake_input_port, osc_halt;
   logic pready, pslverr, perr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [10:0] pc_fetch;
   logic [15:0] word;
   int num_errors = 0;
   int n_checks = 0;
   int n;
   row_t r;

   skip_stop_subtract_exec u_skip_stop_subtract_exec (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wake_input_port(wake_input_port),
      .osc_halt(osc_halt));
   prog_mem_model u_prog_mem_model (.fetch_addr(pc_fetch),
      .fetch_word(word));

   // Free-running 100 MHz clock.
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   // One APB transfer; entered just after a rising edge, holds the request
   // until pready is seen high, then idles one cycle. The idle edge keeps a
   // following call from reassigning psel in the same time step, and lets
   // state launched at the access edge settle before the caller looks.
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // Only pready ends the access; the watchdog bounds a hang.
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      apb(1'h1, a, d, dummy);
   endtask

   // Summary line, verdict and end of the run.
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Watchdog; the whole sequence needs well under a tenth of this span.
   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end

   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wake_input_port = 1'h1;
      pc_fetch = 11'h000;
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      // Table cases: preset memory, flags and counter, run one opcode.
      foreach (rows[i]) begin
         r = rows[i];
         wr(A_MA, 32'h5);
         wr(A_MD, {28'h0, r.mem});
         wr(A_ST, {26'h0, 2'h3, r.acc});
         wr(A_PC, 32'h10);
         wr(A_IN, {16'h0, r.op});
         apb(1'h0, A_ST, 32'h0, q);
         `CHK(q, {26'h0, r.z, r.c, r.racc})
         apb(1'h0, A_PC, 32'h0, q);
         `CHK(q, {21'h0, r.pc})
         apb(1'h0, A_MD, 32'h0, q);
         `CHK(q, {28'h0, r.rmem})
         // A mapped read while awake must not be refused.
         `CHK(perr, 1'h0)
      end
      // Unmapped address: refused and reads as zero.
      apb(1'h0, 8'h14, 32'h0, q);
      `CHK(q, 32'h0)
      `CHK(perr, 1'h1)
      // Short program from the model: skip over word 1, then stop.
      wr(A_MD, 32'h8);
      wr(A_PC, 32'h0);
      repeat (2) begin
         apb(1'h0, A_PC, 32'h0, q);
         pc_fetch <= q[10:0];
         @(posedge pclk);
         wr(A_IN, {16'h0, word});
      end
      `CHK(osc_halt, 1'h1)
      apb(1'h0, A_ST, 32'h0, q);
      `CHK(q[6], 1'h1)
      wr(A_IN, 32'h1A05);
      `CHK(perr, 1'h1)
      repeat (6) @(posedge pclk);
      `CHK(osc_halt, 1'h1)
      wake_input_port <= 1'h0;
      n = 0;
      while (osc_halt !== 1'h0 && n < 10) begin
         @(posedge pclk);
         n++;
      end
      `CHK(osc_halt, 1'h0)
      wake_input_port <= 1'h1;
      apb(1'h0, A_PC, 32'h0, q);
      `CHK(q, 32'h3)
      pc_fetch <= q[10:0];
      @(posedge pclk);
      wr(A_IN, {16'h0, word});
      apb(1'h0, A_ST, 32'h0, q);
      `CHK(q, 32'h15)
      apb(1'h0, A_MD, 32'h0, q);
      `CHK(q, 32'h5)
      // Reset in mid-sleep must clear sleep and the visible state.
      wr(A_IN, {16'h0, skip_stop_pkg::STOP_CODE});
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      `CHK(osc_halt, 1'h0)
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, A_ST, 32'h0, q);
      `CHK(q, 32'h0)
      apb(1'h0, A_PC, 32'h0, q);
      `CHK(q, 32'h0)
      apb(1'h0, A_IN, 32'h0, q);
      `CHK(q, 32'h0)
      print_verdict();
   end
endmodule
